/* inc/tibss_pkg.sv */
// Constants of the timer input and break source select block.
// Assumes one 100 MHz clock and a plain strobe-based register port.
package tibss_pkg;

   // Register port: bit 10 of the address picks the timer, bits 9:0 the offset
   localparam int         ADDR_W          = 11;
   localparam int         TIMER_SEL_BIT   = 10;
   localparam logic [9:0] OFS_BREAK_DT    = 10'h044;
   localparam logic [9:0] OFS_BREAK_CFG   = 10'h060;
   localparam logic [9:0] OFS_INPUT_SEL   = 10'h068;

   // Input select register layout
   localparam int         SEL_LSB         = 0;
   localparam int         SEL_W           = 4;
   localparam logic [3:0] SEL_RESET       = 4'h0;

   // Alternate break configuration register layout
   localparam int         ALT_EN_BIT      = 0;
   localparam int         ALT_POL_BIT     = 9;
   localparam logic [31:0] BREAK_CFG_RESET = 32'h0000_0001;

   // Break and dead-time register: only break enable, polarity and lock kept
   localparam int         MAIN_EN_BIT     = 12;
   localparam int         MAIN_POL_BIT    = 13;
   localparam int         LOCK_LSB        = 8;
   localparam logic [1:0] LOCK_RESET      = 2'h0;
   localparam logic       MAIN_EN_RESET   = 1'b0;
   localparam logic       MAIN_POL_RESET  = 1'b0;

   // Source codes
   localparam logic [3:0] CODE_PIN          = 4'h0;
   localparam logic [3:0] CODE_LS_INT       = 4'h1;
   localparam logic [3:0] CODE_LS_EXT       = 4'h2;
   localparam logic [3:0] CODE_RTC          = 4'h3;
   localparam logic [3:0] CODE_EXT_DIV      = 4'h2;
   localparam logic [3:0] CODE_MAIN_CKOUT   = 4'h3;
   localparam logic [3:0] CODE_SECOND_CKOUT = 4'h4;

   // External clock divider: 32 edges per output period, toggle every half
   localparam int         EXT_DIV         = 32;
   localparam logic [3:0] EXT_HALF_LAST   = 4'(EXT_DIV / 2 - 1);

endpackage : tibss_pkg

/* design/tibss_src_mux.sv */
// One channel-1 source selector with a registered output.
// Assumes the candidate sources are synchronous to clk.
`timescale 1ns/1ps
module tibss_src_mux
   import tibss_pkg::*;
#(
   parameter logic [15:0] VALID_MASK = 16'h0001
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [SEL_W-1:0]  sel,
   input  wire logic [15:0]       cand,
   output logic                   tin
);

   // Unused codes give a quiet low level, never a floating choice
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tin <= 1'b0;
      end else begin
         tin <= VALID_MASK[sel] & cand[sel];
      end
   end

endmodule : tibss_src_mux

/* design/tibss_top.sv */
// Channel-1 source select for two timers and alternate break input of the second.
// Assumes all inputs synchronous to clk; the break output feeds the timer's
// break logic and the channel outputs feed its input filter.
//
// Function
// - Timer A: 4-bit select picks channel-1 source
// - Timer A codes 1..3: oscillators, RTC wakeup
// - Code 4 second clock output per variant
// - Timer B: pin, reserved, external clock/32, clock output
// - Bit 9 sets alternate break polarity
// - Enable ORs alternate break into break sources
// - Lock level freezes alternate break bits
// - Reset values: config 0x1, selects zero
// - Registers accept 16-bit wide accesses
// - Lock field written once after reset
`timescale 1ns/1ps
module tibss_top
   import tibss_pkg::*;
#(
   parameter logic HAS_SECOND_CLOCK_OUTPUT = 1'b1
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [31:0]       wdata,
   input  wire logic [1:0]        wr_half,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic [31:0]            rdata,
   input  wire logic              timer_a_channel1_pin,
   input  wire logic              timer_b_channel1_pin,
   input  wire logic              low_speed_internal_osc,
   input  wire logic              low_speed_external_osc,
   input  wire logic              rtc_wakeup,
   input  wire logic              high_speed_external_clock,
   input  wire logic              main_clock_output,
   input  wire logic              second_clock_output,
   input  wire logic              main_break_pin,
   input  wire logic              alternate_break_input,
   output logic                   timer_a_channel1_timer_input,
   output logic                   timer_b_channel1_timer_input,
   output logic                   break_input
);

   localparam logic [15:0] CKOUT2_BIT = {11'h000, HAS_SECOND_CLOCK_OUTPUT, 4'h0};
   localparam logic [15:0] MASK_A     = 16'h000F | CKOUT2_BIT;
   localparam logic [15:0] MASK_B     = 16'h000D | CKOUT2_BIT;

   logic [SEL_W-1:0] timer_a_sel;
   logic [SEL_W-1:0] timer_b_sel;
   logic             break_pin_enable;
   logic             break_pin_polarity;
   logic             main_break_enable;
   logic             main_break_polarity;
   logic [1:0]       lock_level;
   logic             lock_written;
   logic [3:0]       ext_clk_count;
   logic             ext_clk_prev;
   logic             ext_clk_div32;
   logic [31:0]      next_rdata;
   logic             sel_b;
   logic [9:0]       ofs;
   logic             wr_low;
   logic [15:0]      cand_a;
   logic [15:0]      cand_b;

   assign sel_b  = addr[TIMER_SEL_BIT];
   assign ofs    = addr[9:0];
   // Every field sits in the low half-word, so a 16-bit write suffices
   assign wr_low = wr_en & wr_half[0];

   // Input select registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_a_sel <= SEL_RESET;
         timer_b_sel <= SEL_RESET;
      end else if (wr_low && ofs == OFS_INPUT_SEL) begin
         if (sel_b) begin
            timer_b_sel <= wdata[SEL_LSB +: SEL_W];
         end else begin
            timer_a_sel <= wdata[SEL_LSB +: SEL_W];
         end
      end
   end

   // Lock field takes the first write only, held until reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_level   <= LOCK_RESET;
         lock_written <= 1'b0;
      end else if (wr_low && sel_b && ofs == OFS_BREAK_DT && !lock_written) begin
         lock_level   <= wdata[LOCK_LSB +: 2];
         lock_written <= 1'b1;
      end
   end

   // Main break bits, frozen from lock level 1
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         main_break_enable   <= MAIN_EN_RESET;
         main_break_polarity <= MAIN_POL_RESET;
      end else if (wr_low && sel_b && ofs == OFS_BREAK_DT && lock_level == 2'h0) begin
         main_break_enable   <= wdata[MAIN_EN_BIT];
         main_break_polarity <= wdata[MAIN_POL_BIT];
      end
   end

   // Alternate break configuration, frozen from lock level 1
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         break_pin_enable   <= BREAK_CFG_RESET[ALT_EN_BIT];
         break_pin_polarity <= BREAK_CFG_RESET[ALT_POL_BIT];
      end else if (wr_low && sel_b && ofs == OFS_BREAK_CFG && lock_level == 2'h0) begin
         break_pin_enable   <= wdata[ALT_EN_BIT];
         break_pin_polarity <= wdata[ALT_POL_BIT];
      end
   end

   // Break output: polarity bit clear means the pin is active low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         break_input <= 1'b0;
      end else begin
         break_input <= (main_break_enable &
                         (main_break_pin ~^ main_break_polarity)) |
                        (break_pin_enable &
                         (alternate_break_input ~^ break_pin_polarity));
      end
   end

   // External clock divided by 32; it must run below half the clk rate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_clk_prev  <= 1'b0;
         ext_clk_count <= 4'h0;
         ext_clk_div32 <= 1'b0;
      end else begin
         ext_clk_prev <= high_speed_external_clock;
         if (high_speed_external_clock && !ext_clk_prev) begin
            ext_clk_count <= ext_clk_count + 4'h1;
            if (ext_clk_count == EXT_HALF_LAST) begin
               ext_clk_div32 <= ~ext_clk_div32;
            end
         end
      end
   end

   // Candidate vectors; masks in the selectors keep reserved codes low
   always_comb begin
      cand_a            = 16'h0000;
      cand_a[CODE_PIN]  = timer_a_channel1_pin;
      cand_a[CODE_LS_INT]       = low_speed_internal_osc;
      cand_a[CODE_LS_EXT]       = low_speed_external_osc;
      cand_a[CODE_RTC]          = rtc_wakeup;
      cand_a[CODE_SECOND_CKOUT] = second_clock_output;
      cand_b                    = 16'h0000;
      cand_b[CODE_PIN]          = timer_b_channel1_pin;
      cand_b[CODE_EXT_DIV]      = ext_clk_div32;
      cand_b[CODE_MAIN_CKOUT]   = main_clock_output;
      cand_b[CODE_SECOND_CKOUT] = second_clock_output;
   end

   tibss_src_mux #(
      .VALID_MASK (MASK_A)
   ) u_mux_a (
      .clk  (clk),
      .rst_n(rst_n),
      .sel  (timer_a_sel),
      .cand (cand_a),
      .tin  (timer_a_channel1_timer_input)
   );

   tibss_src_mux #(
      .VALID_MASK (MASK_B)
   ) u_mux_b (
      .clk  (clk),
      .rst_n(rst_n),
      .sel  (timer_b_sel),
      .cand (cand_b),
      .tin  (timer_b_channel1_timer_input)
   );

   // Read path: unmapped offsets read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (rd_en) begin
         if (ofs == OFS_INPUT_SEL) begin
            next_rdata[SEL_LSB +: SEL_W] = sel_b ? timer_b_sel : timer_a_sel;
         end else if (sel_b && ofs == OFS_BREAK_CFG) begin
            next_rdata[ALT_EN_BIT]  = break_pin_enable;
            next_rdata[ALT_POL_BIT] = break_pin_polarity;
         end else if (sel_b && ofs == OFS_BREAK_DT) begin
            next_rdata[LOCK_LSB +: 2] = lock_level;
            next_rdata[MAIN_EN_BIT]   = main_break_enable;
            next_rdata[MAIN_POL_BIT]  = main_break_polarity;
         end
      end
   end

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= next_rdata;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_sel_a_write:
   assert property (wr_en && wr_half[0] && !sel_b && ofs == OFS_INPUT_SEL
                    |=> timer_a_sel == $past(wdata[3:0]))
      else $error("timer A select not stored");

   a_osc_route:
   assert property (timer_a_sel == CODE_LS_INT
                    |=> timer_a_channel1_timer_input == $past(low_speed_internal_osc))
      else $error("oscillator not routed to timer A");

   a_reserved_low:
   assert property (timer_a_sel > CODE_SECOND_CKOUT ||
                    timer_a_sel == CODE_SECOND_CKOUT && !HAS_SECOND_CLOCK_OUTPUT
                    |=> !timer_a_channel1_timer_input)
      else $error("reserved code drives a level");

   a_reserved_low_b:
   assert property (timer_b_sel == 4'h1 || timer_b_sel > CODE_SECOND_CKOUT ||
                    timer_b_sel == CODE_SECOND_CKOUT && !HAS_SECOND_CLOCK_OUTPUT
                    |=> !timer_b_channel1_timer_input)
      else $error("reserved code drives a level on timer B");

   a_pin_route_b:
   assert property (timer_b_sel == CODE_PIN
                    |=> timer_b_channel1_timer_input == $past(timer_b_channel1_pin))
      else $error("timer B pin not routed");

   a_lock_freeze:
   assert property (lock_level != 2'h0 ##1 1'b1
                    |-> $stable(break_pin_enable) && $stable(break_pin_polarity))
      else $error("break bits changed under lock");

   a_lock_once:
   assert property (lock_written ##1 1'b1 |-> $stable(lock_level))
      else $error("lock field rewritten");

   a_break_or:
   assert property (break_pin_enable && (alternate_break_input ~^ break_pin_polarity)
                    |=> break_input)
      else $error("alternate break not passed");

   a_break_off:
   assert property (!break_pin_enable && !main_break_enable |=> !break_input)
      else $error("break raised with sources off");

   a_read_once:
   assert property (!rd_en |=> rdata == 32'h0000_0000)
      else $error("read data outside its cycle");

   a_pin_route_a:
   assert property (timer_a_sel == CODE_PIN
                    |=> timer_a_channel1_timer_input == $past(timer_a_channel1_pin))
      else $error("timer A pin not routed");

   a_lse_route:
   assert property (timer_a_sel == CODE_LS_EXT
                    |=> timer_a_channel1_timer_input == $past(low_speed_external_osc))
      else $error("external oscillator not routed to timer A");

   a_rtc_route:
   assert property (timer_a_sel == CODE_RTC
                    |=> timer_a_channel1_timer_input == $past(rtc_wakeup))
      else $error("wakeup event not routed to timer A");

   a_second_ck_a:
   assert property (HAS_SECOND_CLOCK_OUTPUT && timer_a_sel == CODE_SECOND_CKOUT
                    |=> timer_a_channel1_timer_input == $past(second_clock_output))
      else $error("second clock output not routed to timer A");

   a_second_ck_b:
   assert property (HAS_SECOND_CLOCK_OUTPUT && timer_b_sel == CODE_SECOND_CKOUT
                    |=> timer_b_channel1_timer_input == $past(second_clock_output))
      else $error("second clock output not routed to timer B");

   a_main_ck_route:
   assert property (timer_b_sel == CODE_MAIN_CKOUT
                    |=> timer_b_channel1_timer_input == $past(main_clock_output))
      else $error("clock output not routed to timer B");

   a_div_route:
   assert property (timer_b_sel == CODE_EXT_DIV
                    |=> timer_b_channel1_timer_input == $past(ext_clk_div32))
      else $error("divided clock not routed to timer B");

   // Toggle on every sixteenth detected edge, so one period spans 32 edges
   a_div_toggle:
   assert property (high_speed_external_clock && !ext_clk_prev && ext_clk_count == EXT_HALF_LAST
                    |=> ext_clk_div32 != $past(ext_clk_div32))
      else $error("divider missed its toggle");

   a_div_hold:
   assert property (!(high_speed_external_clock && !ext_clk_prev) |=> $stable(ext_clk_div32))
      else $error("divider moved without an input edge");

   a_break_polarity:
   assert property (!main_break_enable && alternate_break_input != break_pin_polarity
                    |=> !break_input)
      else $error("inactive alternate break level raised break");

   a_cfg_write:
   assert property (wr_en && wr_half[0] && sel_b && ofs == OFS_BREAK_CFG && lock_level == 2'h0
                    |=> break_pin_enable == $past(wdata[ALT_EN_BIT]) &&
                        break_pin_polarity == $past(wdata[ALT_POL_BIT]))
      else $error("break configuration not stored");

   a_half_write:
   assert property (wr_en && !wr_half[0] |=> $stable(timer_a_sel) && $stable(timer_b_sel))
      else $error("upper half write changed a select");

endmodule : tibss_top

/* test/tibss_testbench.sv */
// Self-checking bench for the timer input and break source select block.
// Drives the register port and every source directly; no partner model.
`timescale 1ns/1ps
module testbench;
   import tibss_pkg::*;
   logic              clk, rst_n, wr_en, rd_en, ext_clk, mpin, alt, tin_a, tin_b, bout, p;
   logic [ADDR_W-1:0] addr;
   logic [31:0]       wdata, rdata;
   logic [1:0]        wr_half;
   logic [7:0]        src;
   logic [3:0]        sel_a, sel_b;
   logic              a_en, a_pol, m_en, m_pol, locked, lock_done;
   int                mismatches, cmp_count, n;

   tibss_top i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_half(wr_half), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .timer_a_channel1_pin(src[0]), .timer_b_channel1_pin(src[1]),
      .low_speed_internal_osc(src[2]), .low_speed_external_osc(src[3]),
      .rtc_wakeup(src[4]), .high_speed_external_clock(ext_clk),
      .main_clock_output(src[5]), .second_clock_output(src[6]),
      .main_break_pin(mpin), .alternate_break_input(alt),
      .timer_a_channel1_timer_input(tin_a), .timer_b_channel1_timer_input(tin_b),
      .break_input(bout));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic stop_test();
      if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] cfg_val();
      return (32'(a_pol) << 9) | 32'(a_en);
   endfunction : cfg_val

   // Model follows each write as the design takes it at the strobe edge
   task automatic wr(input logic [10:0] a, input logic [31:0] d, input logic [1:0] h);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_half <= h;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      if (h[0]) begin
         if (a == 11'h068) sel_a = d[3:0];
         if (a == 11'h468) sel_b = d[3:0];
         if (a == 11'h460 && !locked) begin
            a_en = d[0];
            a_pol = d[9];
         end
         if (a == 11'h444) begin
            if (!locked) begin
               m_en = d[12];
               m_pol = d[13];
            end
            if (!lock_done) locked = (d[9:8] != 2'h0);
            lock_done = 1'b1;
         end
      end
   endtask : wr

   task automatic rd(input logic [10:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask : rd

   // Random sources for one cycle, outputs checked one edge later
   task automatic step();
      logic ea, eb, e_bout;
      @(posedge clk);
      src <= 8'($urandom);
      mpin <= 1'($urandom);
      alt <= 1'($urandom);
      @(posedge clk);
      @(negedge clk);
      case (sel_a)
         4'h0: ea = src[0];
         4'h1: ea = src[2];
         4'h2: ea = src[3];
         4'h3: ea = src[4];
         4'h4: ea = src[6];
         default: ea = 1'b0;
      endcase
      case (sel_b)
         4'h0: eb = src[1];
         4'h2: eb = 1'b0;
         4'h3: eb = src[5];
         4'h4: eb = src[6];
         default: eb = 1'b0;
      endcase
      e_bout = (m_en & (mpin == m_pol)) | (a_en & (alt == a_pol));
      chk(32'(tin_a), 32'(ea));
      chk(32'(tin_b), 32'(eb));
      chk(32'(bout), 32'(e_bout));
   endtask : step

   initial begin
      #50000;
      mismatches++;
      stop_test();
   end

   initial begin
      n = $urandom(62520);
      {rst_n, wr_en, rd_en, ext_clk, mpin, alt, addr, wdata, wr_half, src} = '0;
      {sel_a, sel_b, a_pol, m_en, m_pol, locked, lock_done} = '0;
      a_en = 1'b1;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(11'h068, 32'h0);
      rd(11'h468, 32'h0);
      rd(11'h460, 32'h1);
      rd(11'h070, 32'h0);
      rd(11'h060, 32'h0);
      // Divider phase is known only while the clock input has stayed low
      wr(11'h468, 32'h2, 2'b01);
      @(negedge clk);
      p = tin_b;
      n = 0;
      repeat (136) begin
         @(posedge clk);
         ext_clk <= ~ext_clk;
         @(negedge clk);
         if (tin_b !== p) n++;
         p = tin_b;
      end
      chk(32'(n), 32'h4);
      wr(11'h468, 32'h5, 2'b10);
      rd(11'h468, 32'h2);
      for (int c = 0; c < 16; c++) begin
         wr(11'h068, 32'(c), 2'b01);
         wr(11'h468, 32'(c), 2'b01);
         rd(11'h068, 32'(c));
         rd(11'h468, 32'(c));
         repeat (3) step();
      end
      for (int i = 0; i < 4; i++) begin
         wr(11'h460, (32'(i[1]) << 9) | 32'(i[0]), 2'b11);
         rd(11'h460, cfg_val());
         repeat (4) step();
      end
      wr(11'h444, 32'h0000_3100, 2'b01);
      wr(11'h460, 32'h0000_0200, 2'b01);
      wr(11'h444, 32'h0000_0000, 2'b01);
      rd(11'h460, cfg_val());
      rd(11'h444, 32'h0000_3100);
      repeat (8) step();
      // Lock must hold only until the next reset
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      {sel_a, sel_b, a_pol, m_en, m_pol, locked, lock_done} = '0;
      a_en = 1'b1;
      rd(11'h444, 32'h0);
      rd(11'h460, 32'h1);
      rd(11'h468, 32'h0);
      wr(11'h460, 32'h0000_0200, 2'b01);
      rd(11'h460, cfg_val());
      repeat (4) step();
      stop_test();
   end
endmodule : testbench
